//--- adrt_pkg.sv
package adrt_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADRT_OFS_RES_LOW = 8'h00;
	localparam logic [7:0] ADRT_OFS_RES_HIGH = 8'h04;
	localparam logic [7:0] ADRT_OFS_CTRL_B = 8'h08;
	localparam logic [7:0] ADRT_OFS_BUF_OFF_0 = 8'h0C;
	localparam logic [7:0] ADRT_OFS_BUF_OFF_1 = 8'h10;
	localparam logic [7:0] ADRT_OFS_MISC = 8'h14;
	localparam logic [7:0] ADRT_OFS_CONV_CTRL = 8'h18;
	localparam logic [7:0] ADRT_OFS_PIN_IN = 8'h1C;
	localparam logic [7:0] ADRT_OFS_STATUS = 8'h20;

	// ----------------------------------------------------------------
	// Reset values and write masks
	// ----------------------------------------------------------------
	localparam logic [7:0] ADRT_RST_BYTE = 8'h00;
	localparam logic [9:0] ADRT_RST_RESULT = 10'h000;
	localparam logic [31:0] ADRT_RST_WORD = 32'h00000000;
	localparam logic [7:0] ADRT_WMASK_CTRL_B = 8'hF7;
	localparam logic [7:0] ADRT_WMASK_BUF_OFF_0 = 8'hFF;
	localparam logic [7:0] ADRT_WMASK_BUF_OFF_1 = 8'h70;
	localparam logic [7:0] ADRT_WMASK_MISC = 8'h07;
	localparam logic [7:0] ADRT_WMASK_CONV_CTRL = 8'h07;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int ADRT_POS_BIPOLAR = 7;
	localparam int ADRT_POS_TRIG_LSB = 0;
	localparam int ADRT_POS_TRIG_MSB = 2;
	localparam int ADRT_POS_BUF_HIGH_LSB = 4;
	localparam int ADRT_POS_BUF_HIGH_MSB = 6;
	localparam int ADRT_POS_EXT_REF_IN = 2;
	localparam int ADRT_POS_REF_OUT = 1;
	localparam int ADRT_POS_ISRC = 0;
	localparam int ADRT_POS_CONV_EN = 0;
	localparam int ADRT_POS_AUTO_TRIG = 1;
	localparam int ADRT_POS_LEFT_ADJ = 2;

	// ----------------------------------------------------------------
	// Sizes and result constants
	// ----------------------------------------------------------------
	localparam int ADRT_PIN_COUNT = 11;
	localparam int ADRT_TRIG_COUNT = 8;
	localparam logic [9:0] ADRT_RESULT_FULL_SCALE = 10'h3FF;

	// ----------------------------------------------------------------
	// Trigger source codes
	// ----------------------------------------------------------------
	localparam logic [2:0] ADRT_TRIG_FREE_RUN = 3'h0;
	localparam logic [2:0] ADRT_TRIG_COMPARATOR = 3'h1;
	localparam logic [2:0] ADRT_TRIG_EXT_IRQ0 = 3'h2;
	localparam logic [2:0] ADRT_TRIG_T1_CMP_A = 3'h3;
	localparam logic [2:0] ADRT_TRIG_T1_OVF = 3'h4;
	localparam logic [2:0] ADRT_TRIG_T1_CMP_B = 3'h5;
	localparam logic [2:0] ADRT_TRIG_T1_CAPT = 3'h6;
	localparam logic [2:0] ADRT_TRIG_WDT = 3'h7;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		ADRT_LOCK_OPEN = 2'b01,
		ADRT_LOCK_HELD = 2'b10
	} adrt_lock_e;

	typedef struct packed
	{
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} adrt_apb_req_s;

	typedef struct packed
	{
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} adrt_apb_rsp_s;

	typedef struct packed
	{
		logic done;
		logic below;
		logic [9:0] code;
	} adrt_conv_s;

	typedef struct packed
	{
		logic [10:0] buffer_off;
		logic ext_ref_in;
		logic ref_out;
		logic isrc;
		logic bipolar;
		logic start;
	} adrt_ana_s;

	typedef struct packed
	{
		logic [2:0] stage;
		logic level;
	} adrt_sync_s;

endpackage

//--- adrt_pin_sync.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Three-stage pin synchroniser with agreement filter
// ----------------------------------------------------------------
module adrt_pin_sync
	import adrt_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pin,
	output logic level
);

	adrt_sync_s s_r;
	adrt_sync_s s_nxt;

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.stage = {s_r.stage[1:0], pin};
		// Accept a change once stages two and three agree
		if (s_r.stage[1] == s_r.stage[2])
		begin
			s_nxt.level = s_r.stage[2];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_r <= '0;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign level = s_r.level;

endmodule

//--- adrt_top.sv
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/10ps
// Functional notes
// RULE1 - Low byte read freezes both result bytes until high byte is read.
// RULE2 - Software reads low byte first, then high byte, for one conversion.
// RULE3 - Left adjust: bits 9..2 in high byte, bits 1..0 at low 7..6.
// RULE4 - Right adjust default: bits 9..8 at high 1..0, bits 7..0 low.
// RULE5 - Left adjusted eight-bit use may read the high byte alone.
// RULE6 - Unipolar: 10-bit result, saturated when positive not above negative.
// RULE7 - Bipolar select gives two's complement, nine magnitude plus sign.
// RULE8 - Software writes zero to reserved bit 3 of control register b.
// RULE9 - Trigger source field acts only while auto triggering is enabled.
// RULE10 - Auto trigger starts on rising edge of selected source flag.
// RULE11 - Switching from clear source to set source counts as rising edge.
// RULE12 - Switching to free running code zero never creates a trigger.
// RULE13 - Codes: free run, comparator, ext irq0, T1 A, ovf, B, capt, wdt.
// RULE14 - Buffer-off register 0 bits disable input buffers of pins 7..0.
// RULE15 - Buffer-off register 1 bits 6..4 disable pins 10..8.
// RULE16 - Port input bit reads zero while its buffer is disabled.
// RULE17 - Software writes zero to bits 7 and 3..0 of buffer-off register 1.
// RULE18 - Misc bit 2 routes reference from the external reference pin.
// RULE19 - No internal reference with external drive; disable pin buffer too.
// RULE20 - Misc bit 1 drives internal reference out on reference output pin.
// RULE21 - Software writes zero to misc register bits 7..3.
// RULE22 - Adjust select change alters result presentation immediately.
// RULE23 - Auto trigger enable makes selected source edges start conversions.
// RULE24 - After unlock, next completion updates; completions while locked lost.
module adrt_top
	import adrt_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire adrt_apb_req_s apb_req,
	output adrt_apb_rsp_s apb_rsp,
	input wire adrt_conv_s conv,
	input wire logic [7:0] trig_flags,
	input wire logic [10:0] pin_level,
	output adrt_ana_s ana
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic [9:0] result;
		adrt_lock_e lock;
		logic [7:0] ctrl_b;
		logic [7:0] buf_off_0;
		logic [7:0] buf_off_1;
		logic [7:0] misc;
		logic [7:0] conv_ctrl;
		logic trig_prev;
		logic [2:0] sel_prev;
		logic start;
		logic [31:0] prdata;
	} adrt_state_s;

	adrt_state_s s_r;
	adrt_state_s s_nxt;
	logic [10:0] pin_sync;
	logic [10:0] buf_off_all;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < ADRT_PIN_COUNT; gi++)
		begin : g_sync
			adrt_pin_sync u_sync
			(
				.pclk(pclk),
				.presetn(presetn),
				.pin(pin_level[gi]),
				.level(pin_sync[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [9:0] conv_value(input adrt_conv_s c,
		input logic bipolar);
		logic [9:0] mag;
		mag = {1'b0, c.code[8:0]};
		if (bipolar)
		begin
			conv_value = c.below ? 10'(~mag + 10'h001) : mag; // RULE7
		end
		else
		begin
			conv_value = c.below ? ADRT_RESULT_FULL_SCALE : c.code; // RULE6
		end
	endfunction

	function automatic logic [7:0] res_byte(input logic [9:0] r,
		input logic left, input logic high);
		if (left)
		begin
			res_byte = high ? r[9:2] : {r[1:0], 6'h00}; // RULE3
		end
		else
		begin
			res_byte = high ? {6'h00, r[9:8]} : r[7:0]; // RULE4
		end
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		case (a)
			ADRT_OFS_RES_LOW,
			ADRT_OFS_RES_HIGH,
			ADRT_OFS_CTRL_B,
			ADRT_OFS_BUF_OFF_0,
			ADRT_OFS_BUF_OFF_1,
			ADRT_OFS_MISC,
			ADRT_OFS_CONV_CTRL,
			ADRT_OFS_PIN_IN,
			ADRT_OFS_STATUS:
				mapped = 1'b1;
			default:
				mapped = 1'b0;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Trigger source decode
	// ----------------------------------------------------------------
	function automatic logic trig_pick(input logic [7:0] f,
		input logic [2:0] code);
		case (code)
			ADRT_TRIG_FREE_RUN:
				trig_pick = f[0];
			ADRT_TRIG_COMPARATOR:
				trig_pick = f[1];
			ADRT_TRIG_EXT_IRQ0:
				trig_pick = f[2];
			ADRT_TRIG_T1_CMP_A:
				trig_pick = f[3];
			ADRT_TRIG_T1_OVF:
				trig_pick = f[4];
			ADRT_TRIG_T1_CMP_B:
				trig_pick = f[5];
			ADRT_TRIG_T1_CAPT:
				trig_pick = f[6];
			ADRT_TRIG_WDT:
				trig_pick = f[7];
			default:
				trig_pick = 1'b0;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Buffer disable map
	// ----------------------------------------------------------------
	always_comb
	begin
		buf_off_all[7:0] = s_r.buf_off_0; // RULE14
		buf_off_all[10:8] =
			s_r.buf_off_1[ADRT_POS_BUF_HIGH_MSB:ADRT_POS_BUF_HIGH_LSB]; // RULE15
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic setup;
		logic access;
		logic rd_low;
		logic rd_high;
		logic hold;
		logic left;
		logic [2:0] sel;
		logic trig;
		logic edge_seen;
		logic [7:0] rbyte;
		setup = 1'b0;
		access = 1'b0;
		rd_low = 1'b0;
		rd_high = 1'b0;
		hold = 1'b0;
		left = 1'b0;
		sel = 3'h0;
		trig = 1'b0;
		edge_seen = 1'b0;
		rbyte = 8'h00;

		s_nxt = s_r;
		s_nxt.start = 1'b0;
		setup = apb_req.psel && !apb_req.penable;
		access = apb_req.psel && apb_req.penable;
		left = s_r.conv_ctrl[ADRT_POS_LEFT_ADJ];

		// ------------------------------------------------
		// Read data captured in setup phase
		// ------------------------------------------------
		if (setup && !apb_req.pwrite)
		begin
			case (apb_req.paddr)
				ADRT_OFS_RES_LOW:
					rbyte = res_byte(s_r.result, left, 1'b0); // RULE22
				ADRT_OFS_RES_HIGH:
					rbyte = res_byte(s_r.result, left, 1'b1); // RULE22
				ADRT_OFS_CTRL_B:
					rbyte = s_r.ctrl_b & ADRT_WMASK_CTRL_B; // RULE8
				ADRT_OFS_BUF_OFF_0:
					rbyte = s_r.buf_off_0;
				ADRT_OFS_BUF_OFF_1:
					rbyte = s_r.buf_off_1 & ADRT_WMASK_BUF_OFF_1; // RULE17
				ADRT_OFS_MISC:
					rbyte = s_r.misc & ADRT_WMASK_MISC; // RULE21
				ADRT_OFS_CONV_CTRL:
					rbyte = s_r.conv_ctrl;
				ADRT_OFS_PIN_IN:
					rbyte = 8'h00;
				ADRT_OFS_STATUS:
					rbyte = {7'h00, s_r.lock == ADRT_LOCK_HELD};
				default:
					rbyte = 8'h00;
			endcase
			s_nxt.prdata = {24'h000000, rbyte};
			if (apb_req.paddr == ADRT_OFS_PIN_IN)
			begin
				s_nxt.prdata = {21'h000000, pin_sync & ~buf_off_all}; // RULE16
			end
		end

		// ------------------------------------------------
		// Register writes
		// ------------------------------------------------
		if (access && apb_req.pwrite)
		begin
			case (apb_req.paddr)
				ADRT_OFS_CTRL_B:
					s_nxt.ctrl_b = apb_req.pwdata[7:0] & ADRT_WMASK_CTRL_B;
				ADRT_OFS_BUF_OFF_0:
					s_nxt.buf_off_0 = apb_req.pwdata[7:0] & ADRT_WMASK_BUF_OFF_0;
				ADRT_OFS_BUF_OFF_1:
					s_nxt.buf_off_1 = apb_req.pwdata[7:0] & ADRT_WMASK_BUF_OFF_1;
				ADRT_OFS_MISC:
					s_nxt.misc = apb_req.pwdata[7:0] & ADRT_WMASK_MISC;
				ADRT_OFS_CONV_CTRL:
					s_nxt.conv_ctrl = apb_req.pwdata[7:0] & ADRT_WMASK_CONV_CTRL;
				default:
					s_nxt.misc = s_nxt.misc;
			endcase
		end

		// ------------------------------------------------
		// Read lock of the result bytes
		// ------------------------------------------------
		rd_low = access && !apb_req.pwrite && apb_req.paddr == ADRT_OFS_RES_LOW;
		rd_high = access && !apb_req.pwrite &&
			apb_req.paddr == ADRT_OFS_RES_HIGH;
		case (s_r.lock)
			ADRT_LOCK_OPEN:
			begin
				if (rd_low)
				begin
					s_nxt.lock = ADRT_LOCK_HELD; // RULE1
				end
			end
			ADRT_LOCK_HELD:
			begin
				if (rd_high && !rd_low)
				begin
					s_nxt.lock = ADRT_LOCK_OPEN; // RULE24
				end
			end
			default:
				s_nxt.lock = ADRT_LOCK_OPEN;
		endcase

		// ------------------------------------------------
		// Result update, dropped while held or low read pending
		// ------------------------------------------------
		hold = (s_r.lock == ADRT_LOCK_HELD) ||
			(apb_req.psel && !apb_req.pwrite &&
			apb_req.paddr == ADRT_OFS_RES_LOW); // RULE1
		if (conv.done && !hold)
		begin
			s_nxt.result = conv_value(conv,
				s_r.ctrl_b[ADRT_POS_BIPOLAR]); // RULE24
		end

		// ------------------------------------------------
		// Auto trigger edge detection
		// ------------------------------------------------
		sel = s_r.ctrl_b[ADRT_POS_TRIG_MSB:ADRT_POS_TRIG_LSB];
		trig = trig_pick(trig_flags, sel); // RULE13
		edge_seen = trig && !s_r.trig_prev; // RULE10 RULE11
		if (sel == ADRT_TRIG_FREE_RUN && s_r.sel_prev != ADRT_TRIG_FREE_RUN)
		begin
			edge_seen = 1'b0; // RULE12
		end
		s_nxt.trig_prev = trig;
		s_nxt.sel_prev = sel;
		s_nxt.start = edge_seen &&
			s_r.conv_ctrl[ADRT_POS_AUTO_TRIG] &&
			s_r.conv_ctrl[ADRT_POS_CONV_EN]; // RULE9 RULE23
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_r.result <= ADRT_RST_RESULT;
			s_r.lock <= ADRT_LOCK_OPEN;
			s_r.ctrl_b <= ADRT_RST_BYTE;
			s_r.buf_off_0 <= ADRT_RST_BYTE;
			s_r.buf_off_1 <= ADRT_RST_BYTE;
			s_r.misc <= ADRT_RST_BYTE;
			s_r.conv_ctrl <= ADRT_RST_BYTE;
			s_r.trig_prev <= 1'b0;
			s_r.sel_prev <= ADRT_TRIG_FREE_RUN;
			s_r.start <= 1'b0;
			s_r.prdata <= ADRT_RST_WORD;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_comb
	begin
		apb_rsp.prdata = s_r.prdata;
		apb_rsp.pready = apb_req.psel && apb_req.penable;
		apb_rsp.pslverr = apb_req.psel && apb_req.penable &&
			!mapped(apb_req.paddr);
		ana.buffer_off = buf_off_all; // RULE14 RULE15
		ana.ext_ref_in = s_r.misc[ADRT_POS_EXT_REF_IN]; // RULE18
		ana.ref_out = s_r.misc[ADRT_POS_REF_OUT]; // RULE20
		ana.isrc = s_r.misc[ADRT_POS_ISRC];
		ana.bipolar = s_r.ctrl_b[ADRT_POS_BIPOLAR]; // RULE7
		ana.start = s_r.start;
	end

endmodule

//--- adrt_properties.sv
`timescale 1ns/10ps
module adrt_properties
	import adrt_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire adrt_apb_req_s apb_req,
	input wire adrt_apb_rsp_s apb_rsp,
	input wire adrt_conv_s conv,
	input wire logic [7:0] trig_flags,
	input wire logic [10:0] pin_level,
	input wire adrt_ana_s ana
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire acc = apb_req.psel && apb_req.penable;
	wire wr = acc && apb_req.pwrite;
	wire rd = acc && !apb_req.pwrite;
	wire [7:0] adr = apb_req.paddr;
	property p_start_pulse;
		ana.start |=> !ana.start;
	endproperty
	a_start_pulse: assert property (p_start_pulse)
		else $error("start longer than one cycle");
	property p_start_cause;
		ana.start |-> $past(|trig_flags);
	endproperty
	a_start_cause: assert property (p_start_cause)
		else $error("start without any source flag");
	property p_buf_write;
		$changed(ana.buffer_off) |-> $past(wr && (adr == ADRT_OFS_BUF_OFF_0
			|| adr == ADRT_OFS_BUF_OFF_1));
	endproperty
	a_buf_write: assert property (p_buf_write)
		else $error("buffer disable changed without write");
	property p_ext_ref;
		$changed(ana.ext_ref_in) |-> $past(wr && adr == ADRT_OFS_MISC)
			&& ana.ext_ref_in == $past(apb_req.pwdata[2]);
	endproperty
	a_ext_ref: assert property (p_ext_ref)
		else $error("external reference select wrong");
	property p_ref_out;
		$changed(ana.ref_out) |-> $past(wr && adr == ADRT_OFS_MISC)
			&& ana.ref_out == $past(apb_req.pwdata[1]);
	endproperty
	a_ref_out: assert property (p_ref_out)
		else $error("reference output enable wrong");
	property p_bipolar;
		$changed(ana.bipolar) |-> $past(wr && adr == ADRT_OFS_CTRL_B)
			&& ana.bipolar == $past(apb_req.pwdata[7]);
	endproperty
	a_bipolar: assert property (p_bipolar)
		else $error("bipolar mode wrong");
	property p_pin_read;
		rd && adr == ADRT_OFS_PIN_IN
			|-> (apb_rsp.prdata[10:0] & $past(ana.buffer_off)) == 11'h000;
	endproperty
	a_pin_read: assert property (p_pin_read)
		else $error("disabled pin reads one");
	property p_buf1_read;
		rd && adr == ADRT_OFS_BUF_OFF_1
			|-> apb_rsp.prdata[7] == 1'b0 && apb_rsp.prdata[3:0] == 4'h0;
	endproperty
	a_buf1_read: assert property (p_buf1_read)
		else $error("reserved buffer bits read one");
	property p_misc_read;
		rd && adr == ADRT_OFS_MISC |-> apb_rsp.prdata[7:3] == 5'h00;
	endproperty
	a_misc_read: assert property (p_misc_read)
		else $error("reserved misc bits read one");
endmodule
bind adrt_top adrt_properties chk (.pclk, .presetn, .apb_req, .apb_rsp,
	.conv, .trig_flags, .pin_level, .ana);

//--- adrt_partner.sv
`timescale 1ns/10ps
module adrt_partner
	import adrt_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic [9:0] code_set,
	input wire logic below_set,
	output adrt_conv_s conv
);
	logic [2:0] busy_r;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			busy_r <= 3'h0;
		else
			busy_r <= {busy_r[1:0], start};
	// Outside the done pulse the result lines show garbage
	assign conv.done = busy_r[2];
	assign conv.below = busy_r[2] ? below_set : ~below_set;
	assign conv.code = busy_r[2] ? code_set : ~code_set;
endmodule

//--- test_adc_result_trigger_control.sv
`timescale 1ns/10ps
module test_adc_result_trigger_control
	import adrt_pkg::*;
;
	logic pclk = 0;
	logic presetn = 0;
	adrt_apb_req_s req = '0;
	adrt_apb_rsp_s rsp;
	adrt_conv_s conv;
	adrt_ana_s ana;
	logic [7:0] trig = 8'h00;
	logic [10:0] pins = 11'h000;
	logic [9:0] code = 10'h000;
	logic below = 0;
	logic [31:0] rd;
	logic err;
	int err_total = 0;
	int checks = 0;
	int cyc = 0;
	int starts = 0;
	logic [23:0] rows [6] = '{{ADRT_OFS_CTRL_B, 8'hF7, 8'hF7},
		{ADRT_OFS_BUF_OFF_0, 8'hA5, 8'hA5}, {ADRT_OFS_BUF_OFF_1, 8'h70, 8'h70},
		{ADRT_OFS_MISC, 8'h05, 8'h05}, {ADRT_OFS_RES_LOW, 8'hFF, 8'h00},
		{ADRT_OFS_CONV_CTRL, 8'hFF, 8'h07}};
	adrt_top dut (.pclk(pclk), .presetn(presetn), .apb_req(req),
		.apb_rsp(rsp), .conv(conv), .trig_flags(trig), .pin_level(pins),
		.ana(ana));
	adrt_partner conv_model (.pclk(pclk), .presetn(presetn),
		.start(ana.start), .code_set(code), .below_set(below), .conv(conv));
	always #4 pclk = ~pclk;
	task report_and_stop;
		$display("mismatches %0d comparisons %0d", err_total, checks);
		if (err_total == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge pclk)
	begin
		cyc++;
		if (ana.start === 1'b1)
			starts++;
		if (cyc == 5000)
		begin
			err_total++;
			report_and_stop;
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] adr, input logic [31:0] d);
		req <= '{1'b1, 1'b0, w, adr, d};
		@(posedge pclk);
		req.penable <= 1'b1;
		@(posedge pclk);
		while (rsp.pready !== 1'b1)
		begin
			@(posedge pclk);
		end
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge pclk);
	endtask
	task pulse(input int k);
		trig[k] <= 1'b1;
		repeat (8) @(posedge pclk);
		trig[k] <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask
	task rdchk(input logic [7:0] adr, input logic [31:0] exp);
		apb(1'b0, adr, 32'h0);
		chk(rd, exp);
	endtask
	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (rows[i])
		begin
			apb(1'b1, rows[i][23:16], {24'h0, rows[i][15:8]});
			rdchk(rows[i][23:16], {24'h0, rows[i][7:0]});
		end
		chk(ana, {11'h7A5, 4'hB, 1'b0});
		apb(1'b1, ADRT_OFS_MISC, 32'h02);
		chk(ana, {11'h7A5, 4'h5, 1'b0});
		pins <= 11'h7FF;
		repeat (6) @(posedge pclk);
		rdchk(ADRT_OFS_PIN_IN, 32'h05A);
		apb(1'b0, 8'h24, 32'h0);
		chk({err, rd[30:0]}, 32'h80000000);
		presetn <= 1'b0;
		pins <= 11'h000;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int a = 0; a <= 32; a += 4)
			rdchk(a[7:0], 32'h0);
		chk(ana, 32'h0);
		apb(1'b1, ADRT_OFS_CTRL_B, 32'h01);
		apb(1'b1, ADRT_OFS_CONV_CTRL, 32'h03);
		code <= 10'h2C5;
		pulse(1);
		rdchk(ADRT_OFS_RES_LOW, 32'hC5);
		rdchk(ADRT_OFS_RES_HIGH, 32'h02);
		apb(1'b1, ADRT_OFS_CONV_CTRL, 32'h07);
		rdchk(ADRT_OFS_RES_LOW, 32'h40);
		code <= 10'h155;
		pulse(1);
		rdchk(ADRT_OFS_RES_HIGH, 32'hB1);
		pulse(1);
		rdchk(ADRT_OFS_RES_HIGH, 32'h55);
		below <= 1'b1;
		apb(1'b1, ADRT_OFS_CONV_CTRL, 32'h03);
		pulse(1);
		rdchk(ADRT_OFS_RES_LOW, 32'hFF);
		rdchk(ADRT_OFS_RES_HIGH, 32'h03);
		apb(1'b1, ADRT_OFS_CTRL_B, 32'h81);
		code <= 10'h005;
		pulse(1);
		rdchk(ADRT_OFS_RES_LOW, 32'hFB);
		rdchk(ADRT_OFS_RES_HIGH, 32'h03);
		chk(starts, 5);
		apb(1'b1, ADRT_OFS_CONV_CTRL, 32'h01);
		pulse(1);
		chk(starts, 5);
		apb(1'b1, ADRT_OFS_CONV_CTRL, 32'h03);
		trig <= 8'h04;
		repeat (2) @(posedge pclk);
		apb(1'b1, ADRT_OFS_CTRL_B, 32'h02);
		repeat (4) @(posedge pclk);
		chk(starts, 6);
		trig <= 8'h01;
		apb(1'b1, ADRT_OFS_CTRL_B, 32'h01);
		apb(1'b1, ADRT_OFS_CTRL_B, 32'h00);
		repeat (4) @(posedge pclk);
		chk(starts, 6);
		trig <= 8'h00;
		for (int k = 1; k < 8; k++)
		begin
			apb(1'b1, ADRT_OFS_CTRL_B, k);
			pulse(k);
			chk(starts, 6 + k);
		end
		report_and_stop;
	end
endmodule
